//--- design/spc_ctl.sv
`timescale 1ns/1ps
module spc_ctl (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // User request
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  spc_pkg::spc_cmd_e                 req_cmd,
  input  wire logic [spc_pkg::BANK_W-1:0]   req_bank,
  input  wire logic [spc_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic                         req_cke,
  input  wire logic                         req_dq_en,
  input  wire logic [spc_pkg::DATA_W-1:0]   req_wdata,
  input  wire logic [spc_pkg::LANES-1:0]    req_mask,
  // Read return and refresh status
  output logic                              rd_valid,
  output logic [spc_pkg::DATA_W-1:0]        rd_data,
  output logic                              refresh_busy,
  // Pins
  spc_if.ctl                                pins
);
  import spc_pkg::*;

  spc_cst_e              state_r;
  logic [REF_CNT_W-1:0]  ref_cnt_r;
  logic                  ref_pend_r;
  logic [NBANK-1:0]      open_r;
  logic [BL_W-1:0]       bl_r;
  logic [BL_W-1:0]       rd_left_r;
  logic [RD_PIPE-1:0]    rd_sh_r;
  logic [ADDR_W-1:0]     mrs_addr_r;
  logic                  cke_r;
  logic [3:0]            pin_r;
  logic [BANK_W-1:0]     bank_r;
  logic [ADDR_W-1:0]     addr_r;
  logic [LANES-1:0]      mask_r;
  logic [DATA_W-1:0]     dq_r;
  logic [LANES-1:0]      oe_n_r;
  logic                  acc;
  logic                  defer_mrs;
  logic                  ref_go;
  logic                  rd_beat;
  logic                  rd_valid_r;
  logic [DATA_W-1:0]     rd_data_r;

  assign req_ready = (state_r == CST_IDLE) & ~ref_pend_r;
  assign acc       = ce & req_valid & req_ready;
  assign defer_mrs = acc & (req_cmd == CMD_MRS) & (|open_r);
  assign ref_go    = ce & (state_r == CST_IDLE) & ref_pend_r;
  assign rd_beat   = (acc & (req_cmd == CMD_READ)) | (rd_left_r != '0);

  // Refresh timer; a new expiry wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_r  <= '0;
      ref_pend_r <= 1'b0;
    end else if (ce) begin
      if (ref_cnt_r == REF_CNT_W'(REF_INTERVAL_CYC - 1)) begin
        ref_cnt_r  <= '0;
        ref_pend_r <= 1'b1;
      end else begin
        ref_cnt_r <= REF_CNT_W'(ref_cnt_r + 8'h01);
        if (state_r == CST_REF || (ref_go && open_r == '0)) begin
          ref_pend_r <= 1'b0;
        end
      end
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= CST_IDLE;
      open_r     <= '0;
      bl_r       <= 10'h001;
      mrs_addr_r <= MODE_RST;
      cke_r      <= 1'b1;
      pin_r      <= PIN_NOP;
      bank_r     <= '0;
      addr_r     <= '0;
      mask_r     <= '1;
      dq_r       <= '0;
      oe_n_r     <= '1;
    end else if (ce) begin
      pin_r  <= PIN_NOP;
      oe_n_r <= '1;
      unique case (state_r)
        CST_REF: begin
          pin_r   <= spc_encode(CMD_REF);
          state_r <= CST_IDLE;
        end
        CST_MRS: begin
          pin_r   <= spc_encode(CMD_MRS);
          addr_r  <= mrs_addr_r;
          bl_r    <= spc_burst_len(mrs_addr_r[BL_FIELD_W-1:0]);
          state_r <= CST_IDLE;
        end
        default: begin
          if (ref_go) begin
            cke_r <= 1'b1;
            if (|open_r) begin
              pin_r          <= spc_encode(CMD_PRE);
              addr_r[AP_BIT] <= 1'b1;
              open_r         <= '0;
              state_r        <= CST_REF;
            end else begin
              pin_r <= spc_encode(CMD_REF);
            end
          end else if (defer_mrs) begin
            pin_r          <= spc_encode(CMD_PRE);
            addr_r[AP_BIT] <= 1'b1;
            open_r         <= '0;
            mrs_addr_r     <= req_addr;
            state_r        <= CST_MRS;
          end else if (acc) begin
            pin_r  <= spc_encode(req_cmd);
            bank_r <= req_bank;
            addr_r <= req_addr;
            cke_r  <= req_cke;
            mask_r <= req_mask;
            dq_r   <= req_wdata;
            oe_n_r <= {LANES{~req_dq_en}};
            if (req_cmd == CMD_ACT) begin
              open_r[req_bank] <= 1'b1;
            end else if (req_cmd == CMD_PRE) begin
              if (req_addr[AP_BIT]) begin
                open_r <= '0;
              end else begin
                open_r[req_bank] <= 1'b0;
              end
            end else if ((req_cmd == CMD_READ || req_cmd == CMD_WRITE)
                         && req_addr[AP_BIT]) begin
              open_r[req_bank] <= 1'b0;
            end else if (req_cmd == CMD_MRS) begin
              bl_r <= spc_burst_len(req_addr[BL_FIELD_W-1:0]);
            end
          end
        end
      endcase
    end
  end

  // Read return: issue edge plus three edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_left_r  <= '0;
      rd_sh_r    <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else if (ce) begin
      if (acc && req_cmd == CMD_READ) begin
        rd_left_r <= BL_W'(bl_r - 10'h001);
      end else if (acc && req_cmd == CMD_BST) begin
        rd_left_r <= '0;
      end else if (rd_left_r != '0) begin
        rd_left_r <= BL_W'(rd_left_r - 10'h001);
      end
      rd_sh_r    <= {rd_sh_r[RD_PIPE-2:0], rd_beat};
      rd_valid_r <= rd_sh_r[RD_PIPE-1];
      rd_data_r  <= pins.data_io;
    end
  end

  // All pins launched from flops on the rising edge
  assign pins.cke            = cke_r;
  assign pins.cs_n           = pin_r[3];
  assign pins.ras_n          = pin_r[2];
  assign pins.cas_n          = pin_r[1];
  assign pins.we_n           = pin_r[0];
  assign pins.bank_sel       = bank_r;
  assign pins.addr_in        = addr_r;
  assign pins.low_byte_mask  = mask_r[0];
  assign pins.high_byte_mask = mask_r[1];
  assign pins.ctl_dq_out     = dq_r;
  assign pins.ctl_dq_oe_n    = oe_n_r;
  assign rd_valid            = rd_valid_r;
  assign rd_data             = rd_data_r;
  assign refresh_busy        = ref_pend_r | (state_r != CST_IDLE);
endmodule

//--- design/spc_device.sv
`timescale 1ns/1ps
module spc_device (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // Pins
  spc_if.dev                                pins,
  // Status
  output spc_pkg::spc_pwr_e                 pwr_state,
  output logic [spc_pkg::NBANK-1:0]         bank_open,
  output logic [spc_pkg::ADDR_W-1:0]        mode_word
);
  import spc_pkg::*;

  spc_cmd_e              cmd;
  logic                  cke_q_r;
  spc_pwr_e              pwr_r;
  logic                  edge_ok;
  logic                  cmd_ok;
  logic [ADDR_W-1:0]     mode_r;
  logic [NBANK-1:0]      open_r;
  logic [ADDR_W-1:0]     rows_r [NBANK];
  logic                  bact_r;
  logic                  bwr_r;
  logic                  bap_r;
  logic [BANK_W-1:0]     bbank_r;
  logic [COL_W-1:0]      bcol_r;
  logic [BL_W-1:0]       bleft_r;
  logic [BL_W-1:0]       bl;
  logic                  start;
  logic                  beat;
  logic                  cur_wr;
  logic                  last_ap;
  logic [BANK_W-1:0]     cur_bank;
  logic [COL_W-1:0]      cur_col;
  logic [MEM_AW-1:0]     idx;
  logic [LANES-1:0]      mask;
  logic [DATA_W-1:0]     mem [1 << MEM_AW];
  logic                  p1_valid_r;
  logic [DATA_W-1:0]     p1_data_r;
  logic [LANES-1:0]      mq1_r;
  logic [DATA_W-1:0]     out_r;
  logic [LANES-1:0]      oe_n_r;

  // Small array: bank, row bit 0 and low column bits alias the rest
  function automatic logic [MEM_AW-1:0] mem_idx(input logic [BANK_W-1:0] b,
                                                input logic [ADDR_W-1:0] r,
                                                input logic [COL_W-1:0] c);
    return {b, r[0], c[MEM_COL_W-1:0]};
  endfunction

  // Column wraps inside the burst length
  function automatic logic [COL_W-1:0] col_inc(input logic [COL_W-1:0] c,
                                               input logic [BL_W-1:0] n);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] s;
    m = COL_W'(n - 10'h001);
    s = COL_W'(c + 9'h001);
    return (c & ~m) | (s & m);
  endfunction

  assign cmd  = spc_decode({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
  assign mask = {pins.high_byte_mask, pins.low_byte_mask};

  // Gate level from the previous edge qualifies this edge; the gate itself
  // never enters the command decode
  assign edge_ok = ce & cke_q_r;
  assign cmd_ok  = edge_ok & ~pins.cs_n;
  assign bl      = spc_burst_len(mode_r[BL_FIELD_W-1:0]);

  assign start = cmd_ok & ((cmd == CMD_READ) | (cmd == CMD_WRITE))
                 & open_r[pins.bank_sel];
  assign beat     = start | bact_r;
  assign cur_wr   = start ? (cmd == CMD_WRITE) : bwr_r;
  assign cur_bank = start ? pins.bank_sel : bbank_r;
  assign cur_col  = start ? pins.addr_in[COL_W-1:0] : bcol_r;
  assign idx      = mem_idx(cur_bank, rows_r[cur_bank], cur_col);
  assign last_ap  = start ? (pins.addr_in[AP_BIT] & (bl == 10'h001))
                          : (bact_r & bap_r & (bleft_r == 10'h001));

  // Gate tracking and low-power mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cke_q_r <= 1'b1;
      pwr_r   <= PWR_RUN;
    end else if (ce) begin
      cke_q_r <= pins.cke;
      if (cke_q_r && !pins.cke) begin
        if (cmd == CMD_REF) begin
          pwr_r <= PWR_SELF;
        end else if (bact_r) begin
          pwr_r <= PWR_SUSP;
        end else begin
          pwr_r <= PWR_DOWN;
        end
      end else if (pins.cke) begin
        pwr_r <= PWR_RUN;
      end
    end
  end

  // Mode register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RST;
    end else if (cmd_ok && cmd == CMD_MRS) begin
      mode_r <= pins.addr_in;
    end
  end

  // Bank rows and precharge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      open_r <= '0;
      for (int b = 0; b < NBANK; b++) begin
        rows_r[b] <= '0;
      end
    end else if (edge_ok) begin
      if (last_ap) begin
        open_r[cur_bank] <= 1'b0;
      end
      if (cmd_ok && cmd == CMD_ACT) begin
        open_r[pins.bank_sel] <= 1'b1;
        rows_r[pins.bank_sel] <= pins.addr_in;
      end else if (cmd_ok && cmd == CMD_PRE) begin
        if (pins.addr_in[AP_BIT]) begin
          open_r <= '0;
        end else begin
          open_r[pins.bank_sel] <= 1'b0;
        end
      end
    end
  end

  // Burst sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bact_r  <= 1'b0;
      bwr_r   <= 1'b0;
      bap_r   <= 1'b0;
      bbank_r <= '0;
      bcol_r  <= '0;
      bleft_r <= '0;
    end else if (edge_ok) begin
      if (start) begin
        bact_r  <= (bl != 10'h001);
        bwr_r   <= (cmd == CMD_WRITE);
        bap_r   <= pins.addr_in[AP_BIT];
        bbank_r <= pins.bank_sel;
        bcol_r  <= col_inc(pins.addr_in[COL_W-1:0], bl);
        bleft_r <= BL_W'(bl - 10'h001);
      end else if (cmd_ok && cmd == CMD_BST) begin
        bact_r <= 1'b0;
      end else if (bact_r) begin
        bcol_r  <= col_inc(bcol_r, bl);
        bleft_r <= BL_W'(bleft_r - 10'h001);
        if (bleft_r == 10'h001) begin
          bact_r <= 1'b0;
        end
      end
    end
  end

  // Array write; masked lanes keep their old contents
  always_ff @(posedge clk_sys) begin
    if (edge_ok && beat && cur_wr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!mask[l]) begin
          mem[idx][l*LANE_W +: LANE_W] <= pins.data_io[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Read stage: data and mask taken on the same edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p1_valid_r <= 1'b0;
      p1_data_r  <= '0;
      mq1_r      <= '1;
    end else if (edge_ok) begin
      p1_valid_r <= beat & ~cur_wr;
      p1_data_r  <= mem[idx];
      mq1_r      <= mask;
    end
  end

  // Output stage: mask seen two edges before the controller samples
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_r  <= '0;
      oe_n_r <= '1;
    end else if (edge_ok) begin
      out_r <= p1_data_r;
      for (int l = 0; l < LANES; l++) begin
        oe_n_r[l] <= ~(p1_valid_r & ~mq1_r[l]);
      end
    end
  end

  // Drivers off unless a read beat is due, so writes never collide
  assign pins.dev_dq_oe_n = oe_n_r;
  assign pins.dev_dq_out  = out_r;
  assign pwr_state        = pwr_r;
  assign bank_open        = open_r;
  assign mode_word        = mode_r;
endmodule

//--- design/spc_if.sv
`timescale 1ns/1ps
interface spc_if;
  logic                       cke;
  logic                       cs_n;
  logic                       ras_n;
  logic                       cas_n;
  logic                       we_n;
  logic [spc_pkg::BANK_W-1:0] bank_sel;
  logic [spc_pkg::ADDR_W-1:0] addr_in;
  logic                       low_byte_mask;
  logic                       high_byte_mask;
  logic [spc_pkg::DATA_W-1:0] ctl_dq_out;
  logic [spc_pkg::LANES-1:0]  ctl_dq_oe_n;
  logic [spc_pkg::DATA_W-1:0] dev_dq_out;
  logic [spc_pkg::LANES-1:0]  dev_dq_oe_n;
  wire  [spc_pkg::DATA_W-1:0] data_io;

  // Released lane reads as pulled high
  for (genvar i = 0; i < spc_pkg::LANES; i++) begin : g_lane
    assign data_io[i*8 +: 8] = !dev_dq_oe_n[i] ? dev_dq_out[i*8 +: 8] :
                               !ctl_dq_oe_n[i] ? ctl_dq_out[i*8 +: 8] : 8'hff;
  end

  modport dev (
    input  cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr_in,
    input  low_byte_mask, high_byte_mask, data_io,
    output dev_dq_out, dev_dq_oe_n
  );
  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr_in,
    output low_byte_mask, high_byte_mask, ctl_dq_out, ctl_dq_oe_n,
    input  data_io
  );
endinterface

//--- design/spc_pkg.sv
package spc_pkg;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 2;
  localparam int NBANK  = 4;
  localparam int DATA_W = 16;
  localparam int LANES  = 2;
  localparam int LANE_W = 8;
  localparam int COL_W  = 9;
  localparam int BL_W   = 10;
  localparam int AP_BIT = 10;
  localparam int MEM_AW = 10;
  localparam int MEM_COL_W = 7;
  localparam int BL_FIELD_W = 3;

  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic [3:0]        PIN_NOP  = 4'h7;

  localparam int REFRESH_COUNT     = 4096;
  localparam int REFRESH_WINDOW_US = 64000;
  localparam int CLK_MHZ           = 10;
  localparam int REF_INTERVAL_CYC  = REFRESH_WINDOW_US * CLK_MHZ / REFRESH_COUNT;
  localparam int REF_CNT_W         = 8;
  localparam int RD_PIPE           = 3;

  typedef enum logic [3:0] {
    CMD_DESL  = 4'h0,
    CMD_NOP   = 4'h1,
    CMD_BST   = 4'h2,
    CMD_READ  = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_ACT   = 4'h5,
    CMD_PRE   = 4'h6,
    CMD_REF   = 4'h7,
    CMD_MRS   = 4'h8
  } spc_cmd_e;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_SUSP = 2'h2,
    PWR_SELF = 2'h3
  } spc_pwr_e;

  typedef enum logic [1:0] {
    CST_IDLE = 2'h0,
    CST_REF  = 2'h1,
    CST_MRS  = 2'h2
  } spc_cst_e;

  // Pin order {cs_n, ras_n, cas_n, we_n}
  function automatic spc_cmd_e spc_decode(input logic [3:0] p);
    spc_cmd_e c;
    c = CMD_DESL;
    if (!p[3]) begin
      unique case (p[2:0])
        3'h7: c = CMD_NOP;
        3'h6: c = CMD_BST;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h3: c = CMD_ACT;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_MRS;
      endcase
    end
    return c;
  endfunction

  function automatic logic [3:0] spc_encode(input spc_cmd_e c);
    logic [3:0] p;
    p = PIN_NOP;
    unique case (c)
      CMD_DESL:  p = 4'h8;
      CMD_NOP:   p = 4'h7;
      CMD_BST:   p = 4'h6;
      CMD_READ:  p = 4'h5;
      CMD_WRITE: p = 4'h4;
      CMD_ACT:   p = 4'h3;
      CMD_PRE:   p = 4'h2;
      CMD_REF:   p = 4'h1;
      CMD_MRS:   p = 4'h0;
      default:   p = PIN_NOP;
    endcase
    return p;
  endfunction

  // Unlisted codes fall back to a single beat
  function automatic logic [BL_W-1:0] spc_burst_len(input logic [BL_FIELD_W-1:0] f);
    logic [BL_W-1:0] n;
    n = 10'h001;
    unique case (f)
      3'h1:    n = 10'h002;
      3'h2:    n = 10'h004;
      3'h3:    n = 10'h008;
      3'h7:    n = 10'h200;
      default: n = 10'h001;
    endcase
    return n;
  endfunction
endpackage

//--- verif/sdram_pin_command_interface_tb_top.sv
`timescale 1ns/1ps
module sdram_pin_command_interface_tb_top;
  import spc_pkg::*;
  logic        clk_sys, rst_n, ce, req_valid, req_ready, req_cke, req_dq_en;
  logic        rd_valid, refresh_busy;
  spc_cmd_e    req_cmd;
  spc_pwr_e    pwr_state;
  logic [1:0]  req_bank, req_mask;
  logic [11:0] req_addr, mode_word;
  logic [15:0] req_wdata, rd_data;
  logic [3:0]  bank_open;
  logic [15:0] mem_m [1024];
  int          fail_count, check_count;
  spc_if pins_if ();
  spc_device spc_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .pins(pins_if.dev),
    .pwr_state(pwr_state), .bank_open(bank_open), .mode_word(mode_word));
  spc_ctl spc_ctl_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_cke(req_cke), .req_dq_en(req_dq_en), .req_wdata(req_wdata), .req_mask(req_mask),
    .rd_valid(rd_valid), .rd_data(rd_data), .refresh_busy(refresh_busy), .pins(pins_if.ctl));
  spc_assertions spc_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n), .cke(pins_if.cke),
    .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n),
    .bank_sel(pins_if.bank_sel), .addr_in(pins_if.addr_in),
    .low_byte_mask(pins_if.low_byte_mask), .high_byte_mask(pins_if.high_byte_mask),
    .ctl_dq_oe_n(pins_if.ctl_dq_oe_n), .dev_dq_oe_n(pins_if.dev_dq_oe_n));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // Leaves valid high so back-to-back calls never assign it twice in one step
  task automatic issue(input spc_cmd_e c, input logic [1:0] b, input logic [11:0] a,
                       input logic de, input logic [15:0] wd, input logic [1:0] m,
                       input logic k);
    int n;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_dq_en = de;
    req_wdata = wd;
    req_mask = m;
    req_cke = k;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
  endtask
  task automatic idle(input int n);
    req_valid = 1'b0;
    req_dq_en = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask
  // Start right after a refresh so a whole sequence fits before the next one
  task automatic wait_ref();
    int n;
    n = 0;
    while (refresh_busy !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    while (refresh_busy !== 1'b0 && n < 800) begin
      @(negedge clk_sys);
      n++;
    end
    idle(2);
  endtask
  function automatic logic [9:0] idx(input logic [1:0] b, input logic [11:0] r,
                                     input logic [8:0] c);
    return {b, r[0], c[6:0]};
  endfunction
  function automatic logic [8:0] col_at(input logic [8:0] c, input int k, input int bl);
    return (c & ~9'(bl - 1)) | 9'((c + k) & (bl - 1));
  endfunction
  function automatic int bl_of(input logic [2:0] f);
    return (f == 3'h1) ? 2 : (f == 3'h2) ? 4 : (f == 3'h3) ? 8 : 1;
  endfunction
  task automatic wr_burst(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c,
                          input int bl, input logic [1:0] m);
    logic [15:0] d;
    logic [9:0]  ix;
    for (int k = 0; k < bl; k++) begin
      d = 16'($urandom);
      ix = idx(b, r, col_at(c, k, bl));
      if (!m[0]) mem_m[ix][7:0] = d[7:0];
      if (!m[1]) mem_m[ix][15:8] = d[15:8];
      issue(k == 0 ? CMD_WRITE : CMD_NOP, b, {3'h0, c}, 1'b1, d, m, 1'b1);
    end
    idle(2);
  endtask
  task automatic rd_burst(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c,
                          input int bl, input logic [1:0] m, input logic ap);
    logic [15:0] e;
    int          k;
    int          n;
    k = 0;
    n = 0;
    issue(CMD_READ, b, {1'b0, ap, 1'b0, c}, 1'b0, 16'h0000, m, 1'b1);
    req_valid = 1'b0;
    while (k < bl && n < 40) begin
      if (rd_valid === 1'b1) begin
        e = mem_m[idx(b, r, col_at(c, k, bl))];
        if (m[0]) e[7:0] = 8'hff;
        if (m[1]) e[15:8] = 8'hff;
        check(rd_data === e, "read beat");
        k++;
      end
      @(negedge clk_sys);
      n++;
    end
    check(k == bl, "beat count");
    idle(3);
    check(bank_open[b] === !ap, "bank after read");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end
  initial begin
    logic [1:0]  b;
    logic [11:0] r;
    logic [8:0]  c;
    int          bl;
    {rst_n, req_valid, req_dq_en, req_bank, req_addr, req_wdata} = '0;
    {ce, req_cke, req_mask} = 4'hf;
    req_cmd = CMD_NOP;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'hd15b));
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    check(pwr_state === PWR_RUN && bank_open === 4'h0 && mode_word === MODE_RST
          && pins_if.dev_dq_oe_n === 2'b11, "reset values");
    // Even codes leave the bank open, so a second mode load must precharge first
    for (int f = 0; f < 7; f++) begin
      wait_ref();
      issue(CMD_MRS, 2'h0, 12'(f), 1'b0, 16'h0000, 2'b11, 1'b1);
      idle(3);
      check(mode_word === 12'(f) && bank_open === 4'h0, "mode load");
      bl = bl_of(3'(f));
      b = 2'($urandom);
      r = 12'($urandom);
      c = (f == 3) ? 9'h1ff : 9'($urandom);
      issue(CMD_ACT, b, r, 1'b0, 16'h0000, 2'b11, 1'b1);
      idle(1);
      check(bank_open === 4'h1 << b, "activate");
      wr_burst(b, r, c, bl, 2'b00);
      wr_burst(b, r, c, bl, 2'($urandom));
      rd_burst(b, r, c, bl, 2'b00, 1'b0);
      rd_burst(b, r, c, bl, 2'($urandom), 1'(f));
      if (f % 2 == 0) begin
        issue(CMD_MRS, 2'h0, 12'(f), 1'b0, 16'h0000, 2'b11, 1'b1);
        idle(3);
        check(mode_word === 12'(f) && bank_open === 4'h0, "mode after precharge");
      end
      $display("test burst code %0d done", f);
    end
    wait_ref();
    issue(CMD_PRE, 2'h0, 12'h400, 1'b0, 16'h0000, 2'b11, 1'b1);
    issue(CMD_ACT, 2'h1, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    issue(CMD_ACT, 2'h2, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    issue(CMD_PRE, 2'h1, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    idle(2);
    check(bank_open === 4'h4, "precharge one");
    issue(CMD_DESL, 2'h2, 12'h403, 1'b0, 16'h0000, 2'b11, 1'b1);
    idle(2);
    check(bank_open === 4'h4 && mode_word === 12'h006, "deselect");
    issue(CMD_PRE, 2'h3, 12'h400, 1'b0, 16'h0000, 2'b11, 1'b1);
    idle(2);
    check(bank_open === 4'h0, "precharge all");
    issue(CMD_ACT, 2'h1, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    ce = 1'b0;
    idle(3);
    check(bank_open === 4'h0, "frozen edge");
    ce = 1'b1;
    idle(2);
    check(bank_open === 4'h2, "thawed edge");
    issue(CMD_PRE, 2'h0, 12'h400, 1'b0, 16'h0000, 2'b11, 1'b1);
    $display("test precharge done");
    issue(CMD_NOP, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b0);
    issue(CMD_ACT, 2'h3, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b0);
    idle(3);
    check(pwr_state === PWR_DOWN && bank_open === 4'h0, "gated edge");
    issue(CMD_PRE, 2'h0, 12'h400, 1'b0, 16'h0000, 2'b11, 1'b1);
    idle(3);
    check(pwr_state === PWR_RUN, "wake");
    issue(CMD_REF, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b0);
    idle(3);
    check(pwr_state === PWR_SELF, "self refresh");
    issue(CMD_NOP, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    idle(3);
    check(pwr_state === PWR_RUN, "self refresh exit");
    issue(CMD_MRS, 2'h0, 12'h003, 1'b0, 16'h0000, 2'b11, 1'b1);
    issue(CMD_ACT, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    issue(CMD_READ, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    issue(CMD_NOP, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b0);
    idle(2);
    check(pwr_state === PWR_SUSP, "clock suspend");
    issue(CMD_NOP, 2'h0, 12'h000, 1'b0, 16'h0000, 2'b11, 1'b1);
    idle(12);
    check(pwr_state === PWR_RUN && bank_open === 4'h1, "suspend exit");
    $display("test power done");
    complete_run();
  end
endmodule

//--- verif/spc_assertions.sv
`timescale 1ns/1ps
module spc_assertions (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  // Link
  input wire logic                       cke,
  input wire logic                       cs_n,
  input wire logic                       ras_n,
  input wire logic                       cas_n,
  input wire logic                       we_n,
  input wire logic [spc_pkg::BANK_W-1:0] bank_sel,
  input wire logic [spc_pkg::ADDR_W-1:0] addr_in,
  input wire logic                       low_byte_mask,
  input wire logic                       high_byte_mask,
  input wire logic [spc_pkg::LANES-1:0]  ctl_dq_oe_n,
  input wire logic [spc_pkg::LANES-1:0]  dev_dq_oe_n
);
  import spc_pkg::*;
  // Slack of 16 cycles covers a pending precharge or mode load and a short ce stall before the refresh goes out
  localparam int GAP_MAX = REF_INTERVAL_CYC + 16;
  logic [3:0]         pin;
  logic               cke_q_r;
  logic [NBANK-1:0]   open_r;
  logic [REF_CNT_W:0] gap_r;
  assign pin = {cs_n, ras_n, cas_n, we_n};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cke_q_r <= 1'b1;
    else cke_q_r <= cke;
  end
  // Banks open as the link shows them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      open_r <= '0;
    end else if (cke_q_r) begin
      if (pin == 4'h3) open_r[bank_sel] <= 1'b1;
      if (pin == 4'h2 && addr_in[AP_BIT]) open_r <= '0;
      else if (pin == 4'h2 || ((pin == 4'h5 || pin == 4'h4) && addr_in[AP_BIT]))
        open_r[bank_sel] <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) gap_r <= '0;
    else if (pin == 4'h1) gap_r <= '0;
    else gap_r <= gap_r + 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_mask_low_lane:
    assert property (!dev_dq_oe_n[0] |-> !$past(low_byte_mask, 2))
    else $error("low lane driven while masked");
  a_mask_high_lane:
    assert property (!dev_dq_oe_n[1] |-> !$past(high_byte_mask, 2))
    else $error("high lane driven while masked");
  a_read_start:
    assert property (dev_dq_oe_n == 2'b00 && $past(dev_dq_oe_n) == 2'b11
      && !$past(low_byte_mask, 3) && !$past(high_byte_mask, 3) |-> $past(pin, 2) == 4'h5)
    else $error("read data without read command");
  a_no_contention:
    assert property ((dev_dq_oe_n | ctl_dq_oe_n) == 2'b11)
    else $error("both ends drive a lane");
  a_ctl_drive_cmd:
    assert property (ctl_dq_oe_n != 2'b11 |-> pin == 4'h4 || pin == 4'h7)
    else $error("write data outside write burst");
  a_mrs_all_idle:
    assert property (pin == 4'h0 |-> open_r == '0)
    else $error("mode load with open bank");
  a_ref_all_idle:
    assert property (pin == 4'h1 |-> open_r == '0)
    else $error("refresh with open bank");
  a_refresh_due:
    assert property (gap_r <= GAP_MAX)
    else $error("refresh interval exceeded");
  c_read: cover property (pin == 4'h5);
  c_masked_read: cover property (pin == 4'h5 && low_byte_mask);
  c_pre_mrs: cover property (pin == 4'h2 && addr_in[AP_BIT] ##1 pin == 4'h0);
endmodule
